// ---- rtl/ocfg_regs.sv ----
`timescale 1ns/1ps
module ocfg_regs
    import ocfg_pkg::*;
#(
    parameter int PHASE_W = 8
)
(
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               reset_n,
    // register access from the management bus engine
    input  wire logic               regWrite,
    input  wire logic               regRead,
    input  wire logic [7:0]         regAddr,
    input  wire logic [7:0]         regWdata,
    output logic      [7:0]         regRdata,
    // calibration and mode inputs
    input  wire logic               step_pin_mode,
    input  wire logic               squelch_during_cal,
    input  wire logic               out_force_on,
    input  wire logic               calDone,
    input  wire logic               synthClock,
    // output path controls
    output logic      [1:0]         cmos_drive_sel,
    output logic                    cmosDriveEn,
    output logic      [2:0]         out_format_sel,
    output logic                    outDriverOn,
    output logic                    out_buffer_off,
    output logic                    out_divider_one_off,
    output logic                    in_buffer_off,
    // phase alignment
    output logic      [PHASE_W-1:0] appliedPhase,
    output logic                    phaseStepLater,
    output logic                    phaseStepEarlier,
    // gated clock pair
    output logic                    clock_out,
    output logic                    clock_out_n
);

    // =========================================================
    // elaboration check
    generate
        if (PHASE_W != 8)
        begin : g_bad_width
            $error("coarse phase width must be 8");
        end
    endgenerate

    logic [7:0] driveReg;
    logic [7:0] fmtReg;
    logic [7:0] holdReg;
    logic [7:0] opdReg;
    logic [7:0] ipdReg;
    logic [7:0] coarse_phase_offset;
    logic [1:0] wrHold;
    logic       fmtOn;
    logic       squelch;

    logic [2:0] fmtCode;
    logic [1:0] holdCode;
    logic       gateHold;
    logic       gateLevel;

    // merge write data into writable bits, keep reserved bits
    function automatic logic [7:0] merge(input logic [7:0] rstv,
                                         input logic [7:0] mask,
                                         input logic [7:0] data);
        merge = (data & mask) | (rstv & ~mask);
    endfunction

    // =========================================================
    // register writes
    assign wrHold = regWdata[OCFG_HOLD_LSB +: 2];

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            driveReg            <= OCFG_RST_DRIVE;
            fmtReg              <= OCFG_RST_FMT;
            opdReg              <= OCFG_RST_OPD;
            ipdReg              <= OCFG_RST_IPD;
            coarse_phase_offset <= OCFG_RST_PHASE;
        end
        else if (regWrite)
        begin
            if (regAddr == OCFG_ADDR_DRIVE)
                driveReg <= merge(OCFG_RST_DRIVE, OCFG_WM_DRIVE, regWdata);
            if (regAddr == OCFG_ADDR_FMT)
                fmtReg <= merge(OCFG_RST_FMT, OCFG_WM_FMT, regWdata);
            if (regAddr == OCFG_ADDR_OPD)
                opdReg <= merge(OCFG_RST_OPD, OCFG_WM_OPD, regWdata);
            if (regAddr == OCFG_ADDR_IPD)
                ipdReg <= merge(OCFG_RST_IPD, OCFG_WM_IPD, regWdata);
            if (regAddr == OCFG_ADDR_PHASE)
                coarse_phase_offset <= merge(OCFG_RST_PHASE, OCFG_WM_PHASE,
                                             regWdata);
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            holdReg <= OCFG_RST_HOLD;
        else if (regWrite && regAddr == OCFG_ADDR_HOLD &&
                 wrHold != OCFG_HOLD_RSVD)
            holdReg <= merge(OCFG_RST_HOLD, OCFG_WM_HOLD, regWdata);
    end

    // =========================================================
    // register reads; unmapped offsets answer zero
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            regRdata <= OCFG_RD_NONE;
        else if (regRead)
        begin
            unique case (regAddr)
                OCFG_ADDR_DRIVE: regRdata <= driveReg;
                OCFG_ADDR_FMT:   regRdata <= fmtReg;
                OCFG_ADDR_HOLD:  regRdata <= holdReg;
                OCFG_ADDR_OPD:   regRdata <= opdReg;
                OCFG_ADDR_IPD:   regRdata <= ipdReg;
                OCFG_ADDR_PHASE: regRdata <= coarse_phase_offset;
                default:         regRdata <= OCFG_RD_NONE;
            endcase
        end
    end

    // =========================================================
    // output buffer controls
    // LVPECL is accepted as written; the supply check is the host's job
    assign fmtCode = fmtReg[OCFG_FMT_LSB +: 3];
    assign fmtOn   = ocfg_fmt_drives(fmtCode);

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cmos_drive_sel      <= OCFG_RST_DRIVE[OCFG_DRIVE_LSB +: 2];
            cmosDriveEn         <= 1'b0;
            out_format_sel      <= OCFG_RST_FMT[OCFG_FMT_LSB +: 3];
            outDriverOn         <= 1'b0;
            out_buffer_off      <= OCFG_RST_OPD[OCFG_OFF_BIT];
            out_divider_one_off <= OCFG_RST_OPD[OCFG_OFF_BIT];
            in_buffer_off       <= OCFG_RST_IPD[OCFG_IN_BIT];
        end
        else
        begin
            cmos_drive_sel <= driveReg[OCFG_DRIVE_LSB +: 2];
            cmosDriveEn    <= fmtCode == OCFG_FMT_CMOS &&
                              !opdReg[OCFG_OFF_BIT];
            out_format_sel <= fmtCode;
            outDriverOn    <= fmtOn && !opdReg[OCFG_OFF_BIT];
            out_buffer_off      <= opdReg[OCFG_OFF_BIT];
            out_divider_one_off <= opdReg[OCFG_OFF_BIT];
            in_buffer_off <= ipdReg[OCFG_IN_BIT];
        end
    end

    // =========================================================
    // coarse phase: walk one oscillator period per cycle toward the
    // target, so the downstream delay line never jumps
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            appliedPhase     <= OCFG_RST_PHASE;
            phaseStepLater   <= 1'b0;
            phaseStepEarlier <= 1'b0;
        end
        else
        begin
            phaseStepLater   <= 1'b0;
            phaseStepEarlier <= 1'b0;
            // register steers phase only in register mode
            if (!step_pin_mode)
            begin
                if ($signed(appliedPhase) < $signed(coarse_phase_offset))
                begin
                    appliedPhase   <= appliedPhase + 8'h01;
                    phaseStepLater <= 1'b1;
                end
                else if ($signed(appliedPhase) >
                         $signed(coarse_phase_offset))
                begin
                    appliedPhase     <= appliedPhase - 8'h01;
                    phaseStepEarlier <= 1'b1;
                end
            end
        end
    end

    // =========================================================
    // output gating
    // calibration squelch
    assign squelch = squelch_during_cal && !calDone && !out_force_on;

    // driver off and squelch both park the pin low; only a driving
    // output may be held high
    assign holdCode  = holdReg[OCFG_HOLD_LSB +: 2];
    assign gateHold  = squelch || !outDriverOn || holdCode != OCFG_HOLD_RUN;
    assign gateLevel = !squelch && outDriverOn && holdCode == OCFG_HOLD_HIGH;

    ocfg_out_gate u_gate
    (
        .clk_sys     (clk_sys),
        .reset_n     (reset_n),
        .synthClock  (synthClock),
        .holdReq     (gateHold),
        .holdLevel   (gateLevel),
        .clock_out   (clock_out),
        .clock_out_n (clock_out_n)
    );

endmodule // ocfg_regs

// ---- rtl/ocfg_pkg.sv ----
// Summary of operation
// - in CMOS format, bits 7:6 pick 8, 16, 24 or 32 mA drive
// - format field: 001 off, 010 CMOS, 011 low-swing LVDS, 110 CML, 111 LVDS
// - hold field 00 runs the clock, 01 holds it low without glitches
// - hold field 10 holds the clock high glitch-free; 11 is reserved
// - output-off bit 2 powers down output buffer and its divider
// - input control bit 0 set powers down the clock input buffer
// - with step pin mode 0, delay output by coarse phase oscillator periods
// - coarse phase is two's complement, +127 down to -128 periods
// - squelch output during calibration unless the force-on bit is set
package ocfg_pkg;

    // =========================================================
    // register offsets
    localparam logic [7:0] OCFG_ADDR_DRIVE = 8'h05;
    localparam logic [7:0] OCFG_ADDR_FMT   = 8'h06;
    localparam logic [7:0] OCFG_ADDR_HOLD  = 8'h08;
    localparam logic [7:0] OCFG_ADDR_OPD   = 8'h0A;
    localparam logic [7:0] OCFG_ADDR_IPD   = 8'h0B;
    localparam logic [7:0] OCFG_ADDR_PHASE = 8'h10;

    // =========================================================
    // reset values
    localparam logic [7:0] OCFG_RST_DRIVE = 8'hED;
    localparam logic [7:0] OCFG_RST_FMT   = 8'h2D;
    localparam logic [7:0] OCFG_RST_HOLD  = 8'h00;
    localparam logic [7:0] OCFG_RST_OPD   = 8'h00;
    localparam logic [7:0] OCFG_RST_IPD   = 8'h40;
    localparam logic [7:0] OCFG_RST_PHASE = 8'h00;
    localparam logic [7:0] OCFG_RD_NONE   = 8'h00;

    // =========================================================
    // writable bits of each register
    localparam logic [7:0] OCFG_WM_DRIVE = 8'hC0;
    localparam logic [7:0] OCFG_WM_FMT   = 8'h07;
    localparam logic [7:0] OCFG_WM_HOLD  = 8'h30;
    localparam logic [7:0] OCFG_WM_OPD   = 8'h04;
    localparam logic [7:0] OCFG_WM_IPD   = 8'h01;
    localparam logic [7:0] OCFG_WM_PHASE = 8'hFF;

    // =========================================================
    // field positions
    localparam int OCFG_DRIVE_LSB = 6;
    localparam int OCFG_FMT_LSB   = 0;
    localparam int OCFG_HOLD_LSB  = 4;
    localparam int OCFG_OFF_BIT   = 2;
    localparam int OCFG_IN_BIT    = 0;

    // =========================================================
    // format and hold codes
    localparam logic [2:0] OCFG_FMT_OFF    = 3'h1;
    localparam logic [2:0] OCFG_FMT_CMOS   = 3'h2;
    localparam logic [2:0] OCFG_FMT_LSLVDS = 3'h3;
    localparam logic [2:0] OCFG_FMT_LVPECL = 3'h5;
    localparam logic [2:0] OCFG_FMT_CML    = 3'h6;
    localparam logic [2:0] OCFG_FMT_LVDS   = 3'h7;
    localparam logic [1:0] OCFG_HOLD_RUN   = 2'h0;
    localparam logic [1:0] OCFG_HOLD_LOW   = 2'h1;
    localparam logic [1:0] OCFG_HOLD_HIGH  = 2'h2;
    localparam logic [1:0] OCFG_HOLD_RSVD  = 2'h3;

    typedef enum logic {OCFG_GATE_RUN, OCFG_GATE_HELD} ocfg_gate_state_t;

    // reserved codes 000 and 100 leave the driver off
    function automatic logic ocfg_fmt_drives(input logic [2:0] code);
        ocfg_fmt_drives = (code == OCFG_FMT_CMOS)   ||
                          (code == OCFG_FMT_LSLVDS) ||
                          (code == OCFG_FMT_LVPECL) ||
                          (code == OCFG_FMT_CML)    ||
                          (code == OCFG_FMT_LVDS);
    endfunction

endpackage

// ---- rtl/ocfg_out_gate.sv ----
`timescale 1ns/1ps
module ocfg_out_gate
    import ocfg_pkg::*;
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic reset_n,
    // synthesized clock and hold request
    input  wire logic synthClock,
    input  wire logic holdReq,
    input  wire logic holdLevel,
    // gated clock pair
    output logic      clock_out,
    output logic      clock_out_n
);

    ocfg_gate_state_t state;
    logic             heldLevel;
    logic             next_out;

    // =========================================================
    // state: only switch when the clock already sits at the
    // held level, so no runt pulse can appear at either edge
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state     <= OCFG_GATE_HELD;
            heldLevel <= 1'b0;
        end
        else
        begin
            unique case (state)
                OCFG_GATE_RUN:
                begin
                    if (holdReq && synthClock == holdLevel)
                    begin
                        state     <= OCFG_GATE_HELD;
                        heldLevel <= holdLevel;
                    end
                end
                OCFG_GATE_HELD:
                begin
                    if ((!holdReq || holdLevel != heldLevel) &&
                        synthClock == heldLevel)
                        state <= OCFG_GATE_RUN;
                end
            endcase
        end
    end

    always_comb
    begin
        next_out = heldLevel;
        if (state == OCFG_GATE_RUN)
            next_out = synthClock;
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            clock_out   <= 1'b0;
            clock_out_n <= 1'b1;
        end
        else
        begin
            clock_out   <= next_out;
            clock_out_n <= ~next_out;
        end
    end

endmodule // ocfg_out_gate

// ---- sim/ocfg_host_model.sv ----
`timescale 1ns/1ps
module ocfg_host_model
    import ocfg_pkg::*;
#(
    parameter bit SUPPLY_2V5 = 1'b0
)
(
    // clock
    input  wire logic       clk_sys,
    // register port
    output logic            regWrite,
    output logic            regRead,
    output logic      [7:0] regAddr,
    output logic      [7:0] regWdata,
    input  wire logic [7:0] regRdata
);
    initial
    begin
        regWrite = 1'b0;
        regRead  = 1'b0;
        regAddr  = 8'h00;
        regWdata = 8'h00;
    end

    // =========================================================
    // bus cycles
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (a == OCFG_ADDR_FMT && d[2:0] == OCFG_FMT_LVPECL && !SUPPLY_2V5)
            return;
        @(negedge clk_sys);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(negedge clk_sys);
        regWrite <= 1'b0;
        // idle bus shows a changing pattern, not the last value
        regAddr  <= ~a;
        regWdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        regAddr <= a;
        regRead <= 1'b1;
        @(negedge clk_sys);
        regRead <= 1'b0;
        regAddr <= ~a;
        @(negedge clk_sys);
        d = regRdata;
    endtask
endmodule // ocfg_host_model

// ---- sim/ocfg_regs_checker.sv ----
`timescale 1ns/1ps
module ocfg_regs_checker
    import ocfg_pkg::*;
#(
    parameter int PHASE_W = 8
)
(
    // clock and reset
    input wire logic               clk_sys,
    input wire logic               reset_n,
    // register port
    input wire logic               regWrite,
    input wire logic               regRead,
    input wire logic [7:0]         regAddr,
    input wire logic [7:0]         regWdata,
    input wire logic [7:0]         regRdata,
    // modes
    input wire logic               step_pin_mode,
    input wire logic               squelch_during_cal,
    input wire logic               out_force_on,
    input wire logic               calDone,
    // controls
    input wire logic [1:0]         cmos_drive_sel,
    input wire logic               cmosDriveEn,
    input wire logic [2:0]         out_format_sel,
    input wire logic               out_buffer_off,
    input wire logic               out_divider_one_off,
    input wire logic               in_buffer_off,
    input wire logic [PHASE_W-1:0] appliedPhase,
    input wire logic               clock_out
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence wrAt(a); regWrite && regAddr == a; endsequence
    sequence holdWr(c); wrAt(OCFG_ADDR_HOLD) ##0 regWdata[5:4] == c;
    endsequence
    sequence squelched; squelch_during_cal && !calDone && !out_force_on;
    endsequence

    // =========================================================
    // register effects
    AST_DRIVE_SEL: assert property (
        wrAt(OCFG_ADDR_DRIVE) |-> ##2
        cmos_drive_sel == $past(regWdata[7:6], 2))
        else $error("drive code not applied");
    AST_FMT_SEL: assert property (
        wrAt(OCFG_ADDR_FMT) |-> ##2 out_format_sel == $past(regWdata[2:0], 2))
        else $error("format code not applied");
    AST_CMOS_EN: assert property ($past(reset_n) |->
        cmosDriveEn == (out_format_sel == OCFG_FMT_CMOS && !out_buffer_off))
        else $error("cmos drive enable wrong");
    AST_OUT_OFF: assert property (
        wrAt(OCFG_ADDR_OPD) |-> ##2 out_buffer_off == $past(regWdata[2], 2)
        && out_divider_one_off == out_buffer_off)
        else $error("output powerdown wrong");
    AST_IN_OFF: assert property (
        wrAt(OCFG_ADDR_IPD) |-> ##2 in_buffer_off == $past(regWdata[0], 2))
        else $error("input powerdown wrong");
    AST_RSVD_RD: assert property (
        regRead && regAddr == OCFG_ADDR_DRIVE |=> regRdata[5:0] == 6'h2D)
        else $error("reserved drive bits changed");
    AST_UNMAPPED: assert property (regRead && !(regAddr inside
        {8'h05, 8'h06, 8'h08, 8'h0A, 8'h0B, 8'h10}) |=> regRdata == 8'h00)
        else $error("unmapped read not zero");
    AST_PHASE_HOLD: assert property (
        step_pin_mode |=> $stable(appliedPhase))
        else $error("phase moved with pin mode set");
    AST_HOLD_LOW: assert property (
        holdWr(2'h1) |-> ##[2:10] (!clock_out) [*4])
        else $error("hold low not reached");
    AST_HOLD_HIGH: assert property (
        holdWr(2'h2) |-> ##[2:10] clock_out [*4])
        else $error("hold high not reached");
    AST_SQUELCH: assert property (
        squelched [*8] |-> !clock_out)
        else $error("output not squelched");
endmodule // ocfg_regs_checker

bind ocfg_regs ocfg_regs_checker #(.PHASE_W(PHASE_W)) u_chk (.clk_sys,
    .reset_n, .regWrite, .regRead, .regAddr, .regWdata, .regRdata,
    .step_pin_mode, .squelch_during_cal, .out_force_on, .calDone,
    .cmos_drive_sel, .cmosDriveEn, .out_format_sel, .out_buffer_off,
    .out_divider_one_off, .in_buffer_off, .appliedPhase, .clock_out);

// ---- sim/tb_output_clock_config_regs.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    err_total++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_output_clock_config_regs import ocfg_pkg::*;;
    logic       clk_sys, reset_n, regWrite, regRead, calDone, synthClock;
    logic       step_pin_mode, squelch_during_cal, out_force_on;
    logic       cmosDriveEn, outDriverOn, out_buffer_off;
    logic       out_divider_one_off, in_buffer_off, clock_out, clock_out_n;
    logic       phaseStepLater, phaseStepEarlier;
    logic [7:0] regAddr, regWdata, regRdata, appliedPhase, rdv;
    logic [1:0] cmos_drive_sel;
    logic [2:0] out_format_sel;
    int         err_total = 0, checks_done = 0, nEarly = 0, nLate = 0;
    int         nBase = 0, i;
    logic [7:0] adr [6] = '{OCFG_ADDR_DRIVE, OCFG_ADDR_FMT, OCFG_ADDR_HOLD,
                            OCFG_ADDR_OPD, OCFG_ADDR_IPD, OCFG_ADDR_PHASE};
    logic [7:0] rst [6] = '{OCFG_RST_DRIVE, OCFG_RST_FMT, OCFG_RST_HOLD,
                            OCFG_RST_OPD, OCFG_RST_IPD, OCFG_RST_PHASE};
    logic [7:0] wm [6]  = '{OCFG_WM_DRIVE, OCFG_WM_FMT, OCFG_WM_HOLD,
                            OCFG_WM_OPD, OCFG_WM_IPD, OCFG_WM_PHASE};

    ocfg_regs dut (.clk_sys, .reset_n, .regWrite, .regRead, .regAddr,
        .regWdata, .regRdata, .step_pin_mode, .squelch_during_cal,
        .out_force_on, .calDone, .synthClock, .cmos_drive_sel, .cmosDriveEn,
        .out_format_sel, .outDriverOn, .out_buffer_off, .out_divider_one_off,
        .in_buffer_off, .appliedPhase, .phaseStepLater, .phaseStepEarlier,
        .clock_out, .clock_out_n);
    ocfg_host_model host (.clk_sys, .regWrite, .regRead, .regAddr,
        .regWdata, .regRdata);

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // synthesized clock with a period of four reference cycles
    initial
    begin
        synthClock = 1'b0;
        forever
        begin
            repeat (2) @(negedge clk_sys);
            synthClock = ~synthClock;
        end
    end
    // pulses are counted away from the edge that launches them
    always @(negedge clk_sys)
    begin
        nEarly += int'(phaseStepEarlier === 1'b1);
        nLate  += int'(phaseStepLater === 1'b1);
    end

    // =========================================================
    // helpers
    task automatic waitc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        host.wr(a, d);
        waitc(2);
    endtask
    task automatic chkrd(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, rdv);
        `CHK("regRdata", e, rdv)
    endtask
    task automatic obs(input logic [1:0] m);
        int hi;
        int lo;
        int ex;
        hi = 0;
        lo = 0;
        ex = m == 2'h0 ? 0 : m == 2'h1 ? 8 : 4;
        waitc(6);
        repeat (8)
        begin
            @(negedge clk_sys);
            hi += int'(clock_out === 1'b1);
            lo += int'(clock_out === 1'b0);
            `CHK("clock_out_n", ~clock_out, clock_out_n)
        end
        `CHK("clock_out highs", ex, hi)
        `CHK("clock_out lows", 8 - ex, lo)
    endtask
    task automatic settle(input logic [7:0] e);
        for (int k = 0; k < 400 && appliedPhase !== e; k++)
            @(negedge clk_sys);
        `CHK("appliedPhase", e, appliedPhase)
        if (appliedPhase !== e)
            conclude();
    endtask
    task automatic conclude();
        $display("TB: checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // =========================================================
    // tests
    initial
    begin
        reset_n = 1'b0;
        step_pin_mode = 1'b0;
        squelch_during_cal = 1'b0;
        out_force_on = 1'b0;
        calDone = 1'b1;
        waitc(10);
        reset_n = 1'b1;
        for (i = 0; i < 6; i++)
            chkrd(adr[i], rst[i]);
        `CHK("out_format_sel", OCFG_FMT_LVPECL, out_format_sel)
        `CHK("outDriverOn", 1'b1, outDriverOn)
        `CHK("cmos_drive_sel", OCFG_RST_DRIVE[7:6], cmos_drive_sel)
        $display("test reset values done");
        for (i = 0; i < 6; i++)
        begin
            // hold code 11 drops the whole write
            w(adr[i], 8'hFF);
            chkrd(adr[i], i == 2 ? rst[i] : rst[i] | wm[i]);
            w(adr[i], 8'h00);
            chkrd(adr[i], rst[i] & ~wm[i]);
        end
        w(8'h07, 8'h5A);
        chkrd(8'h07, 8'h00);
        $display("test access kinds done");
        w(OCFG_ADDR_FMT, 8'h02);
        for (i = 0; i < 4; i++)
        begin
            w(OCFG_ADDR_DRIVE, 8'(i << 6));
            `CHK("cmos_drive_sel", 2'(i), cmos_drive_sel)
            `CHK("cmosDriveEn", 1'b1, cmosDriveEn)
        end
        for (i = 0; i < 8; i++)
        begin
            if (i == 5)
                continue;
            w(OCFG_ADDR_FMT, 8'(i));
            `CHK("out_format_sel", 3'(i), out_format_sel)
            `CHK("outDriverOn", 1'(i > 1 && i != 4), outDriverOn)
        end
        w(OCFG_ADDR_OPD, 8'h04);
        `CHK("outDriverOn", 1'b0, outDriverOn)
        `CHK("out_divider_one_off", 1'b1, out_divider_one_off)
        w(OCFG_ADDR_OPD, 8'h00);
        `CHK("out_buffer_off", 1'b0, out_buffer_off)
        w(OCFG_ADDR_IPD, 8'h01);
        `CHK("in_buffer_off", 1'b1, in_buffer_off)
        w(OCFG_ADDR_IPD, 8'h00);
        `CHK("in_buffer_off", 1'b0, in_buffer_off)
        $display("test output controls done");
        w(OCFG_ADDR_PHASE, 8'h7F);
        settle(8'h7F);
        nBase = nEarly;
        w(OCFG_ADDR_PHASE, 8'h80);
        settle(8'h80);
        waitc(2);
        `CHK("earlier steps", 255, nEarly - nBase)
        step_pin_mode = 1'b1;
        w(OCFG_ADDR_PHASE, 8'h00);
        waitc(20);
        `CHK("appliedPhase", 8'h80, appliedPhase)
        nBase = nLate;
        step_pin_mode = 1'b0;
        settle(8'h00);
        waitc(2);
        `CHK("later steps", 128, nLate - nBase)
        $display("test coarse phase done");
        w(OCFG_ADDR_HOLD, 8'h10);
        obs(2'h0);
        w(OCFG_ADDR_HOLD, 8'h20);
        obs(2'h1);
        w(OCFG_ADDR_HOLD, 8'h30);
        chkrd(OCFG_ADDR_HOLD, 8'h20);
        w(OCFG_ADDR_HOLD, 8'h00);
        obs(2'h2);
        $display("test static hold done");
        squelch_during_cal = 1'b1;
        calDone = 1'b0;
        obs(2'h0);
        out_force_on = 1'b1;
        obs(2'h2);
        out_force_on = 1'b0;
        calDone = 1'b1;
        obs(2'h2);
        $display("test squelch done");
        // a mid-run reset must bring back the reset image
        reset_n = 1'b0;
        waitc(2);
        reset_n = 1'b1;
        chkrd(OCFG_ADDR_FMT, OCFG_RST_FMT);
        `CHK("out_format_sel", OCFG_FMT_LVPECL, out_format_sel)
        $display("test mid-run reset done");
        conclude();
    end
endmodule // tb_output_clock_config_regs
